// *** logic/trn_buffer_ram.sv ***
// internal packet buffer, single port, registered read
`timescale 1ns/1ps
module trn_buffer_ram (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [trn_pkg::RAM_AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);

  logic [7:0] mem [trn_pkg::RAM_DEPTH];

  // ===========================================================
  // contents are not reset; software fills the pages
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end

endmodule

// *** logic/trn_host_regs.sv ***
// host register bank of a token passing node controller
// Functional notes
// - fourteen registers; undefined bits read zero here, host writes zero to them
// - outside chained mode, each mask bit sits at the position of the flag it gates
// - only receiver inhibit, successor change, excess nak, recon, tx available interrupt
// - interrupt is the or of each maskable flag anded with its mask bit
// - masking hides receiver or transmitter interrupt, flag stays, unmasking reasserts
// - clear-flags command clears the recon interrupt condition
// - only power-on-clear-flags command clears the excess nak condition
// - reading the successor identifier clears the successor changed flag
// - hardware reset zeroes the interrupt mask
// - data port reads or writes buffer ram at the pointer
// - writing pointer low in read direction loads the data port once
// - index 7 sub-address 0..4 picks probe, own id, setup a, successor/test, setup b
// - host writes probe id; device flags when that node is seen
// - probing cannot see the token successor; only successor register shows it
// - only hardware reset zeroes the probe identifier
// - core stays idle while own identifier is zero
// - nonzero id wakes core; joining needs transmit enable; receiver always runs
// - only hardware reset zeroes the own identifier
// - successor register is read only and updated by the core
// - each successor update sets the change flag; any reset zeroes it
// - status read only, resets to one at bits 7, 4, 0
// - while chaining, status bits take their chained meaning
// - host writes pointer high then low; low write loads the pointer
// - config write sets sub-address bits 1:0 and clears bit 2
// - diagnostic read clears flags except excess nak and successor change; any reset clears all of them
`timescale 1ns/1ps
module trn_host_regs (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ri_set_in,
  input wire logic ri_clr_in,
  input wire logic ta_set_in,
  input wire logic ta_clr_in,
  input wire logic recon_evt_in,
  input wire logic test_level_in,
  input wire logic tma_level_in,
  input wire logic chain_tri_in,
  input wire logic chain_tta_in,
  input wire logic myrecon_evt_in,
  input wire logic duplicate_identifier_flag_evt_in,
  input wire logic rcvact_evt_in,
  input wire logic token_evt_in,
  input wire logic excess_negative_ack_flag_evt_in,
  input wire logic probe_seen_in,
  input wire logic successor_load_in,
  input wire logic [7:0] successor_id_in,
  output logic irq_out,
  output logic cmd_strobe_out,
  output logic [7:0] cmd_code_out,
  output logic core_awake_out,
  output logic transmit_enable_out,
  output logic soft_reset_out,
  output logic [7:0] own_identifier_out,
  output logic [7:0] probe_identifier_out,
  output logic [7:0] node_configuration_out,
  output logic [7:0] speed_setup_a_out,
  output logic [7:0] timing_setup_b_out
);

  // ===========================================================
  // bus decode
  logic take, rd_take, wr_take, ack_q;
  logic pf1_q, pf2_q, aligned;
  logic [2:0] idx;
  logic [7:0] wbyte;
  logic srst;

  // pointer wrap across the 2k buffer
  function automatic logic [10:0] ptr_step(input logic [10:0] p);
    ptr_step = 11'(p + 11'h001);
  endfunction

  // one register index: byte address bits 1:0 must be zero
  function automatic logic hit(input logic [2:0] want, input logic [2:0] at, input logic ok);
    hit = ok && (at == want);
  endfunction

  assign aligned = (avs_address_in[1:0] == 2'h0);
  assign idx = avs_address_in[4:2];
  assign wbyte = avs_writedata_in[7:0];
  // prefetch stalls the bus so a read never sees stale data
  assign take = (avs_read_in | avs_write_in) & ~ack_q & ~pf1_q & ~pf2_q;
  assign rd_take = take & avs_read_in;
  assign wr_take = take & avs_write_in & avs_byteenable_in[0];
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;

  // ===========================================================
  // registers
  logic [7:0] mask_q;
  logic [7:0] cfg_q;
  logic [2:0] bank_q;
  logic [7:0] ptrh_q;
  logic [10:0] ptr_q;
  logic [7:0] data_q;
  logic [7:0] probe_q;
  logic [7:0] own_q;
  logic [7:0] setup_a_q;
  logic [7:0] setup_b_q;
  logic [7:0] succ_q;
  logic ri_q, ta_q, recon_q, por_q, myrecon_q, duplicate_identifier_flag_q;
  logic rcvact_q, token_q, excess_negative_ack_flag_q, probe_identifier_q, newnext_q;
  logic [7:0] status_v;
  logic [7:0] diag_v;
  logic [7:0] rd_d;
  logic [7:0] ram_rdata;
  logic clr_flags, por_clr, diag_rd, succ_rd, data_rd, data_wr, low_wr;

  assign srst = cfg_q[trn_pkg::CFG_RESET_BIT];
  assign clr_flags = wr_take && hit(trn_pkg::IDX_DIAG, idx, aligned) && wbyte == trn_pkg::CMD_CLEAR_FLAGS;
  assign por_clr = wr_take && hit(trn_pkg::IDX_DIAG, idx, aligned) && wbyte == trn_pkg::CMD_POR_CLEAR;
  assign diag_rd = rd_take && hit(trn_pkg::IDX_DIAG, idx, aligned);
  assign succ_rd = rd_take && hit(trn_pkg::IDX_BANKED, idx, aligned) && bank_q == trn_pkg::SUB_SUCCESSOR;
  assign data_rd = rd_take && hit(trn_pkg::IDX_DATA, idx, aligned);
  assign data_wr = wr_take && hit(trn_pkg::IDX_DATA, idx, aligned);
  assign low_wr = wr_take && hit(trn_pkg::IDX_PTR_LOW, idx, aligned);

  // ===========================================================
  // bus answer: one cycle after the request is taken
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      ack_q <= take;
      if (rd_take) begin
        avs_readdata_out <= {24'h00_0000, rd_d};
      end
    end
  end

  // ===========================================================
  // mask, hardware reset only
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mask_q <= trn_pkg::MASK_RST;
    end else if (wr_take && hit(trn_pkg::IDX_STATUS, idx, aligned)) begin
      mask_q <= wbyte & trn_pkg::MASK_WMASK;
    end
  end

  // ===========================================================
  // configuration and sub-address share bits 1:0
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cfg_q <= trn_pkg::CFG_RST;
      bank_q <= 3'h0;
    end else if (wr_take && hit(trn_pkg::IDX_CONFIG, idx, aligned)) begin
      cfg_q <= {wbyte[7:2], 2'h0};
      bank_q <= {1'b0, wbyte[1:0]};
    end else if (wr_take && hit(trn_pkg::IDX_BANK_SEL, idx, aligned)) begin
      bank_q <= wbyte[2:0];
    end
  end

  // ===========================================================
  // command strobe toward the core
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cmd_strobe_out <= 1'b0;
      cmd_code_out <= trn_pkg::ZERO_RST;
    end else begin
      cmd_strobe_out <= wr_take && hit(trn_pkg::IDX_DIAG, idx, aligned);
      if (wr_take && hit(trn_pkg::IDX_DIAG, idx, aligned)) begin
        cmd_code_out <= wbyte;
      end
    end
  end

  // ===========================================================
  // banked registers at index 7; probe and own id survive soft reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      probe_q <= trn_pkg::ID_RST;
      own_q <= trn_pkg::ID_RST;
      setup_a_q <= trn_pkg::SETUP_RST;
      setup_b_q <= trn_pkg::SETUP_RST;
    end else if (wr_take && hit(trn_pkg::IDX_BANKED, idx, aligned)) begin
      unique case (bank_q)
        trn_pkg::SUB_PROBE: probe_q <= wbyte;
        trn_pkg::SUB_OWN_ID: own_q <= wbyte;
        trn_pkg::SUB_SETUP_A: setup_a_q <= wbyte & trn_pkg::SETUP_A_WMASK;
        trn_pkg::SUB_SETUP_B: setup_b_q <= wbyte & trn_pkg::SETUP_B_WMASK;
        default: ; // test register write and empty codes are dropped
      endcase
    end
  end

  // ===========================================================
  // successor id, loaded by the core, cleared by any reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in || srst) begin
      succ_q <= trn_pkg::ZERO_RST;
    end else if (successor_load_in) begin
      succ_q <= successor_id_in;
    end
  end

  // ===========================================================
  // status flags; a set in the clear cycle wins
  always_ff @(posedge clk_in) begin
    if (!rstn_in || srst) begin
      ri_q <= 1'b1;
      ta_q <= 1'b1;
      por_q <= 1'b1;
      recon_q <= 1'b0;
    end else begin
      ri_q <= ri_set_in | (ri_q & ~ri_clr_in);
      ta_q <= ta_set_in | (ta_q & ~ta_clr_in);
      por_q <= por_q & ~clr_flags;
      recon_q <= recon_evt_in | (recon_q & ~clr_flags);
    end
  end

  // ===========================================================
  // diagnostic flags, most clear on read
  always_ff @(posedge clk_in) begin
    if (!rstn_in || srst) begin
      myrecon_q <= 1'b0;
      duplicate_identifier_flag_q <= 1'b0;
      rcvact_q <= 1'b0;
      token_q <= 1'b0;
      probe_identifier_q <= 1'b0;
      excess_negative_ack_flag_q <= 1'b0;
      newnext_q <= 1'b0;
    end else begin
      myrecon_q <= myrecon_evt_in | (myrecon_q & ~diag_rd);
      duplicate_identifier_flag_q <= duplicate_identifier_flag_evt_in | (duplicate_identifier_flag_q & ~diag_rd);
      rcvact_q <= rcvact_evt_in | (rcvact_q & ~diag_rd);
      token_q <= token_evt_in | (token_q & ~diag_rd);
      // the successor never answers a probe, so such a hit is dropped
      probe_identifier_q <= (probe_seen_in && probe_q != succ_q) | (probe_identifier_q & ~diag_rd);
      excess_negative_ack_flag_q <= excess_negative_ack_flag_evt_in | (excess_negative_ack_flag_q & ~por_clr);
      newnext_q <= successor_load_in | (newnext_q & ~succ_rd);
    end
  end

  // chained mode moves receiver and transmitter bits
  always_comb begin
    if (cfg_q[trn_pkg::CFG_CHAIN_BIT]) begin
      status_v = {chain_tri_in, ri_q, ta_q, por_q, test_level_in, recon_q, tma_level_in, chain_tta_in};
    end else begin
      status_v = {ri_q, 2'b00, por_q, test_level_in, recon_q, tma_level_in, ta_q};
    end
  end

  assign diag_v = {myrecon_q, duplicate_identifier_flag_q, rcvact_q, token_q, excess_negative_ack_flag_q, probe_identifier_q, newnext_q, 1'b0};

  // ===========================================================
  // address pointer; low write loads the whole pointer
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ptrh_q <= trn_pkg::ZERO_RST;
      ptr_q <= 11'h000;
    end else if (wr_take && hit(trn_pkg::IDX_PTR_HIGH, idx, aligned)) begin
      ptrh_q <= wbyte & trn_pkg::PTRH_WMASK;
    end else if (low_wr) begin
      ptr_q <= {ptrh_q[2:0], wbyte};
    end else if ((data_rd | data_wr) && ptrh_q[trn_pkg::PTR_INC_BIT]) begin
      ptr_q <= ptr_step(ptr_q);
    end
  end

  // ===========================================================
  // prefetch: pointer settles, ram reads, data port loads
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pf1_q <= 1'b0;
      pf2_q <= 1'b0;
    end else begin
      pf1_q <= ptrh_q[trn_pkg::PTR_READ_DIR_BIT] & (low_wr | (data_rd & ptrh_q[trn_pkg::PTR_INC_BIT]));
      pf2_q <= pf1_q;
    end
  end

  // data port; reads zero after reset until first load
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      data_q <= trn_pkg::ZERO_RST;
    end else if (data_wr) begin
      data_q <= wbyte;
    end else if (pf2_q) begin
      data_q <= ram_rdata;
    end
  end

  trn_buffer_ram u_ram (
    .clk_in(clk_in),
    .we_in(data_wr),
    .addr_in(ptr_q),
    .wdata_in(wbyte),
    .rdata_out(ram_rdata)
  );

  // ===========================================================
  // read multiplexer; unmapped or misaligned reads give zero
  always_comb begin
    rd_d = trn_pkg::ZERO_RST;
    if (aligned) begin
      unique case (idx)
        trn_pkg::IDX_STATUS: rd_d = status_v;
        trn_pkg::IDX_DIAG: rd_d = diag_v;
        trn_pkg::IDX_PTR_HIGH: rd_d = {ptrh_q[7:6], 3'b000, ptr_q[10:8]};
        trn_pkg::IDX_PTR_LOW: rd_d = ptr_q[7:0];
        trn_pkg::IDX_DATA: rd_d = data_q;
        trn_pkg::IDX_BANK_SEL: rd_d = {5'b00000, bank_q};
        trn_pkg::IDX_CONFIG: rd_d = {cfg_q[7:2], bank_q[1:0]};
        trn_pkg::IDX_BANKED: begin
          unique case (bank_q)
            trn_pkg::SUB_PROBE: rd_d = probe_q;
            trn_pkg::SUB_OWN_ID: rd_d = own_q;
            trn_pkg::SUB_SETUP_A: rd_d = setup_a_q;
            trn_pkg::SUB_SUCCESSOR: rd_d = succ_q;
            trn_pkg::SUB_SETUP_B: rd_d = setup_b_q;
            default: rd_d = trn_pkg::ZERO_RST;
          endcase
        end
      endcase
    end
  end

  // ===========================================================
  // interrupt: flags in their mask positions
  trn_irq_combine u_irq (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .flags_in({ri_q, 3'b000, excess_negative_ack_flag_q, recon_q, newnext_q, ta_q}),
    .mask_in(mask_q),
    .irq_out(irq_out)
  );

  // ===========================================================
  // core control levels
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      core_awake_out <= 1'b0;
      transmit_enable_out <= 1'b0;
    end else begin
      core_awake_out <= (own_q != trn_pkg::ID_RST);
      transmit_enable_out <= (own_q != trn_pkg::ID_RST) & cfg_q[trn_pkg::CFG_TRANSMIT_ENABLE_BIT_BIT];
    end
  end

  assign soft_reset_out = srst;
  assign own_identifier_out = own_q;
  assign probe_identifier_out = probe_q;
  assign node_configuration_out = {cfg_q[7:2], bank_q[1:0]};
  assign speed_setup_a_out = setup_a_q;
  assign timing_setup_b_out = setup_b_q;

endmodule

// *** logic/trn_irq_combine.sv ***
// interrupt gating of the maskable status and diagnostic flags
`timescale 1ns/1ps
module trn_irq_combine (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] mask_in,
  output logic irq_out
);

  // ===========================================================
  // and each flag with its mask, or the results
  // the mask never touches the flag, so re-enabling shows it again
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(flags_in & mask_in & trn_pkg::MASK_WMASK);
    end
  end

endmodule

// *** logic/trn_pkg.sv ***
// shared constants for the token ring node host register bank
package trn_pkg;

  // ===========================================================
  // register word indices (byte address is four times the index)
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_DIAG = 3'h1;
  localparam logic [2:0] IDX_PTR_HIGH = 3'h2;
  localparam logic [2:0] IDX_PTR_LOW = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [2:0] IDX_BANK_SEL = 3'h5;
  localparam logic [2:0] IDX_CONFIG = 3'h6;
  localparam logic [2:0] IDX_BANKED = 3'h7;

  // sub-address values behind index 7
  localparam logic [2:0] SUB_PROBE = 3'h0;
  localparam logic [2:0] SUB_OWN_ID = 3'h1;
  localparam logic [2:0] SUB_SETUP_A = 3'h2;
  localparam logic [2:0] SUB_SUCCESSOR = 3'h3;
  localparam logic [2:0] SUB_SETUP_B = 3'h4;

  // ===========================================================
  // field positions
  localparam int STAT_RI_BIT = 7;
  localparam int STAT_POR_BIT = 4;
  localparam int STAT_RECON_BIT = 2;
  localparam int STAT_TA_BIT = 0;
  localparam int DIAG_EXCESS_NEGATIVE_ACK_FLAG_BIT = 3;
  localparam int DIAG_NEWNEXT_BIT = 1;
  localparam int PTR_READ_DIR_BIT = 7;
  localparam int PTR_INC_BIT = 6;
  localparam int CFG_RESET_BIT = 7;
  localparam int CFG_CHAIN_BIT = 6;
  localparam int CFG_TRANSMIT_ENABLE_BIT_BIT = 5;

  // ===========================================================
  // write masks: undefined bits are never stored
  localparam logic [7:0] MASK_WMASK = 8'h8F;
  localparam logic [7:0] PTRH_WMASK = 8'hC7;
  localparam logic [7:0] SETUP_A_WMASK = 8'hDF;
  localparam logic [7:0] SETUP_B_WMASK = 8'h8F;

  // ===========================================================
  // reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h18;
  localparam logic [7:0] ID_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] ZERO_RST = 8'h00;

  // command codes decoded locally (all codes also go to the core)
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h1E;
  localparam logic [7:0] CMD_POR_CLEAR = 8'h0E;

  // buffer ram geometry
  localparam int RAM_AW = 11;
  localparam int RAM_DEPTH = 2048;

endpackage

// *** tb/testbench.sv ***
// self-checking bench for the host register bank
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic wr;
    logic [4:0] adr;
    logic [7:0] dat;
    logic [7:0] exp;
  } trn_row_t;
  logic clk_in;
  logic rstn_in;
  logic [11:0] ev;
  logic [7:0] succ_id;
  logic [4:0] adr;
  logic rd, wr, wait_r, irq, strobe, awake, transmit_enable_bit;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0] be;
  logic [7:0] code, own_id, probe_id;
  int n_mismatch = 0;
  int n_tests = 0;
  // =========================================================
  // register table walk: write rows and read rows in table order, reads with expected value
  trn_row_t rows [28] = '{
    '{1'h0, 5'h00, 8'h00, 8'h91}, '{1'h0, 5'h04, 8'h00, 8'h00}, '{1'h0, 5'h18, 8'h00, 8'h18},
    '{1'h0, 5'h14, 8'h00, 8'h00}, '{1'h0, 5'h1C, 8'h00, 8'h00}, '{1'h1, 5'h18, 8'h19, 8'h00},
    '{1'h0, 5'h18, 8'h00, 8'h19}, '{1'h0, 5'h14, 8'h00, 8'h01}, '{1'h1, 5'h1C, 8'h2A, 8'h00},
    '{1'h0, 5'h1C, 8'h00, 8'h2A}, '{1'h1, 5'h14, 8'h04, 8'h00}, '{1'h1, 5'h1C, 8'hFF, 8'h00},
    '{1'h0, 5'h1C, 8'h00, 8'h8F}, '{1'h1, 5'h18, 8'h1A, 8'h00}, '{1'h0, 5'h14, 8'h00, 8'h02},
    '{1'h1, 5'h1C, 8'hFF, 8'h00}, '{1'h0, 5'h1C, 8'h00, 8'hDF}, '{1'h1, 5'h14, 8'h03, 8'h00},
    '{1'h1, 5'h1C, 8'h00, 8'h00}, '{1'h0, 5'h1C, 8'h00, 8'h00}, '{1'h1, 5'h14, 8'h05, 8'h00},
    '{1'h0, 5'h1C, 8'h00, 8'h00}, '{1'h1, 5'h14, 8'h00, 8'h00}, '{1'h1, 5'h1C, 8'h5C, 8'h00},
    '{1'h0, 5'h1C, 8'h00, 8'h5C}, '{1'h1, 5'h04, 8'h00, 8'h00}, '{1'h0, 5'h08, 8'h00, 8'h00},
    '{1'h0, 5'h00, 8'h00, 8'h91}
  }; // test register only ever written with zero
  trn_host_model trn_host_model_inst (.clk_in(clk_in), .waitrequest_in(wait_r), .readdata_in(rdat),
    .address_out(adr), .read_out(rd), .write_out(wr), .writedata_out(wdat), .byteenable_out(be));
  trn_host_regs trn_host_regs_inst (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r), .ri_set_in(ev[0]), .ri_clr_in(ev[1]),
    .ta_set_in(ev[2]), .ta_clr_in(ev[3]), .recon_evt_in(ev[4]), .test_level_in(1'h0), .tma_level_in(1'h0),
    .chain_tri_in(1'h0), .chain_tta_in(1'h0), .myrecon_evt_in(ev[5]), .duplicate_identifier_flag_evt_in(ev[6]),
    .rcvact_evt_in(ev[7]), .token_evt_in(ev[8]), .excess_negative_ack_flag_evt_in(ev[9]), .probe_seen_in(ev[10]),
    .successor_load_in(ev[11]), .successor_id_in(succ_id), .irq_out(irq), .cmd_strobe_out(strobe),
    .cmd_code_out(code), .core_awake_out(awake), .transmit_enable_out(transmit_enable_bit), .soft_reset_out(),
    .own_identifier_out(own_id), .probe_identifier_out(probe_id), .node_configuration_out(),
    .speed_setup_a_out(), .timing_setup_b_out());
  // clock
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  // =========================================================
  // helpers; every stimulus ends off the edge, after effects have landed
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({31'h00000000, got}, {31'h00000000, exp});
  endtask
  task automatic bw(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    trn_host_model_inst.xfer(1'h1, a, d, q);
    repeat (3) @(negedge clk_in);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    trn_host_model_inst.xfer(1'h0, a, 8'h00, q);
    chk(q, {24'h000000, e});
    repeat (3) @(negedge clk_in);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_in);
    ev[b] <= 1'h1;
    @(posedge clk_in);
    ev <= 12'h000;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic hw_reset;
    @(posedge clk_in);
    rstn_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'h1;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end
    else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rstn_in = 1'h0;
    ev = 12'h000;
    succ_id = 8'h33;
    hw_reset;
    foreach (rows[i]) begin
      if (rows[i].wr) bw(rows[i].adr, rows[i].dat);
      else rdc(rows[i].adr, rows[i].exp);
    end
    trn_host_model_inst.set_pointer(8'h00, 8'h10);
    bw(5'h10, 8'hA5);
    trn_host_model_inst.set_pointer(8'h00, 8'h11);
    bw(5'h10, 8'h3C);
    trn_host_model_inst.set_pointer(8'h80, 8'h10);
    rdc(5'h10, 8'hA5);
    rdc(5'h10, 8'hA5);
    rdc(5'h08, 8'h80);
    trn_host_model_inst.set_pointer(8'hC0, 8'h10);
    rdc(5'h10, 8'hA5);
    rdc(5'h10, 8'h3C);
    rdc(5'h08, 8'hC0);
    $display("test table done");
    chb(irq, 1'h0);
    bw(5'h00, 8'h80);
    chb(irq, 1'h1);
    bw(5'h00, 8'h00);
    chb(irq, 1'h0);
    rdc(5'h00, 8'h91);
    bw(5'h00, 8'h80);
    chb(irq, 1'h1);
    pulse(1);
    chb(irq, 1'h0);
    bw(5'h00, 8'h01);
    chb(irq, 1'h1);
    pulse(3);
    chb(irq, 1'h0);
    bw(5'h00, 8'h8F);
    $display("test mask done");
    pulse(4);
    chb(irq, 1'h1);
    rdc(5'h00, 8'h14);
    bw(5'h04, 8'h1E);
    chk({24'h000000, code}, 32'h0000001E);
    chb(irq, 1'h0);
    pulse(9);
    rdc(5'h04, 8'h08);
    rdc(5'h04, 8'h08);
    bw(5'h04, 8'h1E);
    chb(irq, 1'h1);
    bw(5'h04, 8'h0E);
    chb(irq, 1'h0);
    for (int i = 5; i < 9; i++) begin
      pulse(i);
      chb(irq, 1'h0);
      rdc(5'h04, 8'(8'h80 >> (i - 5)));
    end
    $display("test commands done");
    pulse(11);
    chb(irq, 1'h1);
    pulse(10);
    rdc(5'h04, 8'h06);
    rdc(5'h04, 8'h02);
    bw(5'h14, 8'h03);
    rdc(5'h1C, 8'h33);
    chb(irq, 1'h0);
    rdc(5'h04, 8'h00);
    bw(5'h14, 8'h00);
    bw(5'h1C, 8'h33);
    pulse(10);
    rdc(5'h04, 8'h00);
    $display("test successor done");
    chb(awake, 1'h1);
    chb(transmit_enable_bit, 1'h0);
    bw(5'h18, 8'h38);
    chb(transmit_enable_bit, 1'h1);
    bw(5'h18, 8'h18);
    chb(transmit_enable_bit, 1'h0);
    pulse(0);
    bw(5'h18, 8'h98);
    rdc(5'h00, 8'h91);
    rdc(5'h1C, 8'h33);
    bw(5'h18, 8'h1B);
    rdc(5'h1C, 8'h00);
    bw(5'h18, 8'h19);
    rdc(5'h1C, 8'h2A);
    bw(5'h00, 8'h80);
    hw_reset;
    chb(irq, 1'h0);
    chk({24'h000000, probe_id, own_id}, 32'h00000000);
    chb(awake, 1'h0);
    $display("test resets done");
    stop_test;
  end
  // watchdog: the run needs well under a thousand cycles, this allows forty thousand
  initial begin
    #400000;
    n_mismatch++;
    stop_test;
  end
endmodule
bind trn_host_regs trn_host_regs_props trn_host_regs_props_inst (.clk_in, .rstn_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .irq_out, .cmd_strobe_out, .core_awake_out, .transmit_enable_out, .soft_reset_out, .own_identifier_out,
  .probe_identifier_out, .node_configuration_out);

// *** tb/trn_host_model.sv ***
// host processor model driving the register bus
`timescale 1ns/1ps
module trn_host_model (
  input wire logic clk_in,
  input wire logic waitrequest_in,
  input wire logic [31:0] readdata_in,
  output logic [4:0] address_out,
  output logic read_out,
  output logic write_out,
  output logic [31:0] writedata_out,
  output logic [3:0] byteenable_out
);
  // =========================================================
  // idle bus at time zero, low lane only
  initial begin
    address_out = 5'h00;
    read_out = 1'h0;
    write_out = 1'h0;
    writedata_out = 32'h00000000;
    byteenable_out = 4'h1;
  end
  // one transfer; request held until waitrequest is sampled low at a rising edge
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_in);
    address_out <= a;
    writedata_out <= {24'h000000, d}; // upper lanes always zero
    write_out <= wr;
    read_out <= ~wr;
    @(posedge clk_in);
    while (waitrequest_in !== 1'h0) @(posedge clk_in);
    q = readdata_in;
    read_out <= 1'h0;
    write_out <= 1'h0;
  endtask
  // pointer is loaded by its low byte, so high goes first
  task automatic set_pointer(input logic [7:0] hi, input logic [7:0] lo);
    logic [31:0] q;
    xfer(1'h1, 5'h08, hi, q);
    xfer(1'h1, 5'h0C, lo, q);
  endtask
endmodule

// *** tb/trn_host_regs_props.sv ***
// port-level checks on the host register bank
`timescale 1ns/1ps
module trn_host_regs_props (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out,
  input wire logic cmd_strobe_out,
  input wire logic core_awake_out,
  input wire logic transmit_enable_out,
  input wire logic soft_reset_out,
  input wire logic [7:0] own_identifier_out,
  input wire logic [7:0] probe_identifier_out,
  input wire logic [7:0] node_configuration_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic wr_done;
  // =========================================================
  // write completion as the host sees it
  assign wr_done = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  // interrupt, command and identifier relations
  AST_IRQ_RESET: assert property ($rose(rstn_in) |-> !irq_out ##1 !irq_out)
    else $error("interrupt high right after reset");
  AST_MASK_OFF: assert property (wr_done && avs_address_in == 5'h00 && avs_writedata_in[7:0] == 8'h00
    |-> ##1 !irq_out [*2]) else $error("interrupt with all mask bits clear");
  AST_CORE_IDLE: assert property ((own_identifier_out == 8'h00) [*2] |-> !core_awake_out)
    else $error("core awake with zero own identifier");
  AST_TX_CORE: assert property ((!core_awake_out) [*2] |-> !transmit_enable_out)
    else $error("transmitter enabled while core asleep");
  AST_TX_OFF: assert property (wr_done && avs_address_in == 5'h18 && !avs_writedata_in[5]
    |-> ##1 !transmit_enable_out) else $error("transmitter on after enable cleared");
  AST_CFG_STORE: assert property (wr_done && avs_address_in == 5'h18 |-> ##1
    node_configuration_out == $past(avs_writedata_in[7:0]) && soft_reset_out == $past(avs_writedata_in[7]))
    else $error("configuration write not stored");
  AST_OWN_HOLD: assert property ($past(rstn_in) && $changed(own_identifier_out)
    |-> $past(avs_write_in) && $past(avs_address_in) == 5'h1C) else $error("own identifier changed by itself");
  AST_PROBE_HOLD: assert property ($past(rstn_in) && $changed(probe_identifier_out)
    |-> $past(avs_write_in) && $past(avs_address_in) == 5'h1C) else $error("probe identifier changed by itself");
  AST_CMD_PULSE: assert property ($rose(cmd_strobe_out) |-> $past(avs_write_in)
    && $past(avs_address_in) == 5'h04 ##1 !cmd_strobe_out) else $error("command strobe without command write");
  AST_READ_UPPER: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  AST_WAIT_BOUND: assert property ($rose(avs_read_in || avs_write_in) |-> ##[1:8] !avs_waitrequest_out)
    else $error("bus request not answered");
  // main scenarios reached
  COV_MASK: cover property (wr_done && avs_address_in == 5'h00 && avs_writedata_in[7]);
  COV_TRANSMIT_ENABLE_BIT: cover property (wr_done && avs_address_in == 5'h18 && avs_writedata_in[5]);
  COV_BANKED: cover property (avs_read_in && !avs_waitrequest_out && avs_address_in == 5'h1C);
endmodule
